// ==== src/fsic_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module fsic_top (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_b,
   // Avalon-MM slave
   input  wire logic [3:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   // Interrupt sources
   input  wire fsic_pkg::fsic_src_t   src_in,
   // Core handshake
   input  wire logic                  core_poll_ok,
   input  wire logic                  vector_taken,
   input  wire logic                  return_from_interrupt,
   output fsic_pkg::fsic_vec_t        vec_out,
   output logic [1:0]                 level_busy
);

   // ==========================================================
   // State record
   typedef struct packed {
      logic [7:0]            enable;      // irq_enable_reg
      logic [7:0]            priority_;   // irq_priority_reg
      logic [7:0]            tctrl;       // timer_control_reg trigger bits
      logic [6:0]            flags;       // Request flags
      logic                  mode_prev;   // Mode level of last cycle
      logic                  ext1_prev;   // Ext1 level of last cycle
      logic [4:0]            sample;      // Sampled requests, polled next
      logic                  in_prog_lo;  // Low level service running
      logic                  in_prog_hi;  // High level service running
      logic                  rd_ack;      // Read answer cycle
      logic                  wr_ack;      // Write answer cycle
      logic [31:0]           rdata;       // Registered read data
      fsic_pkg::fsic_state_t state;       // Vectoring handshake state
      fsic_pkg::fsic_vec_t   vec;         // Offered vector
      logic                  blocked;     // Enable or priority write blocks next poll
   } fsic_state_rec_t;

   fsic_state_rec_t st_reg;   // Current state
   fsic_state_rec_t st_next;  // Next state

   // ==========================================================
   // Synchronised pin inputs
   logic [1:0] pins_sync;     // [1] mode change, [0] ext1

   fsic_sync #(
      .WIDTH (2)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .async_in ({src_in.mode_change, src_in.ext1_pin}),
      .sync_out (pins_sync)
   );

   // ==========================================================
   // Arbitration
   logic       arb_found;     // A poll winner exists
   logic [2:0] arb_winner;    // Winning source index
   logic       arb_high;      // Winner sits at high level
   logic [4:0] high_sel;      // Per-source level bits
   logic [4:0] gated_req;     // Enabled samples

   // Level bit per source in polling order
   always_comb begin
      high_sel[fsic_pkg::SRC_MODE] = st_reg.priority_[fsic_pkg::EN_MODE_BIT];
      high_sel[fsic_pkg::SRC_DDC]  = st_reg.priority_[fsic_pkg::EN_DDC_BIT];
      high_sel[fsic_pkg::SRC_TMR0] = st_reg.priority_[fsic_pkg::EN_TMR0_BIT];
      high_sel[fsic_pkg::SRC_EXT1] = st_reg.priority_[fsic_pkg::EN_EXT1_BIT];
      high_sel[fsic_pkg::SRC_TMR1] = st_reg.priority_[fsic_pkg::EN_TMR1_BIT];
   end

   fsic_arbiter u_arb (
      .request     (gated_req),
      .high_sel    (high_sel),
      .allow_low   (!st_reg.in_prog_lo && !st_reg.in_prog_hi),
      .allow_high  (!st_reg.in_prog_hi),
      .found       (arb_found),
      .winner      (arb_winner),
      .winner_high (arb_high)
   );

   // ==========================================================
   // Vector lookup, used for offer
   function automatic logic [15:0] vec_of(input logic [2:0] s);
      logic [15:0] v;
      case (s)
         fsic_pkg::SRC_MODE: v = fsic_pkg::VEC_MODE;
         fsic_pkg::SRC_DDC:  v = fsic_pkg::VEC_DDC;
         fsic_pkg::SRC_TMR0: v = fsic_pkg::VEC_TMR0;
         fsic_pkg::SRC_EXT1: v = fsic_pkg::VEC_EXT1;
         default:            v = fsic_pkg::VEC_TMR1;
      endcase
      return v;
   endfunction

   // ==========================================================
   // Request lines seen by the sampler
   logic [4:0] raw_req;       // Live request per source
   logic       mode_edge;     // Falling edge on mode line
   logic       ext1_edge;     // Falling edge on ext1 line
   logic       mode_is_edge;  // Mode change trigger select
   logic       ext1_is_edge;  // Ext1 trigger select
   logic       wr_hit;        // Accepted write this cycle

   always_comb begin
      mode_is_edge = st_reg.tctrl[fsic_pkg::TC_MODE_TRIG];
      ext1_is_edge = st_reg.tctrl[fsic_pkg::TC_EXT1_TRIG];
      // Active-low inputs, as on the classic core pins
      mode_edge = st_reg.mode_prev && !pins_sync[1];
      ext1_edge = st_reg.ext1_prev && !pins_sync[0];
      raw_req[fsic_pkg::SRC_MODE] = st_reg.flags[fsic_pkg::FL_MODE];
      raw_req[fsic_pkg::SRC_DDC]  = st_reg.flags[fsic_pkg::FL_SERIAL]
                                  | st_reg.flags[fsic_pkg::FL_DISPLAY]
                                  | st_reg.flags[fsic_pkg::FL_HOSTSW];
      raw_req[fsic_pkg::SRC_TMR0] = st_reg.flags[fsic_pkg::FL_TMR0];
      raw_req[fsic_pkg::SRC_EXT1] = st_reg.flags[fsic_pkg::FL_EXT1];
      raw_req[fsic_pkg::SRC_TMR1] = st_reg.flags[fsic_pkg::FL_TMR1];
      gated_req = (st_reg.enable[fsic_pkg::EN_GLOBAL_BIT] && !st_reg.blocked)
                ? (st_reg.sample & {st_reg.enable[fsic_pkg::EN_TMR1_BIT],
                                    st_reg.enable[fsic_pkg::EN_EXT1_BIT],
                                    st_reg.enable[fsic_pkg::EN_TMR0_BIT],
                                    st_reg.enable[fsic_pkg::EN_DDC_BIT],
                                    st_reg.enable[fsic_pkg::EN_MODE_BIT]})
                : 5'h00;
      wr_hit = avs_write && st_reg.wr_ack;
   end

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic       take;     // Core took the offered vector
      logic [2:0] ts;       // Taken source
      st_next = st_reg;
      take    = (st_reg.state == fsic_pkg::FSIC_OFFER) && vector_taken;
      ts      = st_reg.vec.source;

      // Line history for edge detection
      st_next.mode_prev = pins_sync[1];
      st_next.ext1_prev = pins_sync[0];
      st_next.rd_ack    = 1'b0;
      st_next.wr_ack    = avs_write && !st_reg.wr_ack;
      st_next.blocked   = 1'b0;

      // Hardware clears on vectoring; sets below win over them
      if (take) begin
         if (ts == fsic_pkg::SRC_MODE && mode_is_edge) begin
            st_next.flags[fsic_pkg::FL_MODE] = 1'b0;
         end
         if (ts == fsic_pkg::SRC_EXT1 && ext1_is_edge) begin
            st_next.flags[fsic_pkg::FL_EXT1] = 1'b0;
         end
         if (ts == fsic_pkg::SRC_TMR0) begin
            st_next.flags[fsic_pkg::FL_TMR0] = 1'b0;
         end
         if (ts == fsic_pkg::SRC_TMR1) begin
            st_next.flags[fsic_pkg::FL_TMR1] = 1'b0;
         end
      end

      // Register writes; flag writes behave like hardware
      if (wr_hit) begin
         if (avs_address == fsic_pkg::ADDR_ENABLE) begin
            st_next.enable  = avs_writedata[7:0];
            st_next.blocked = 1'b1;
         end else if (avs_address == fsic_pkg::ADDR_PRIORITY) begin
            st_next.priority_ = avs_writedata[7:0];
            st_next.blocked   = 1'b1;
         end else if (avs_address == fsic_pkg::ADDR_TCTRL) begin
            st_next.tctrl = avs_writedata[7:0];
         end else if (avs_address == fsic_pkg::ADDR_FLAGS) begin
            st_next.flags = avs_writedata[6:0];
         end
      end

      // Level sources follow the line; edge sources latch
      if (mode_is_edge) begin
         if (mode_edge) begin
            st_next.flags[fsic_pkg::FL_MODE] = 1'b1;
         end
      end else begin
         st_next.flags[fsic_pkg::FL_MODE] = !pins_sync[1];
      end
      if (ext1_is_edge) begin
         if (ext1_edge) begin
            st_next.flags[fsic_pkg::FL_EXT1] = 1'b1;
         end
      end else begin
         st_next.flags[fsic_pkg::FL_EXT1] = !pins_sync[0];
      end
      // Overflow and DDC events set their flags
      if (src_in.tmr0_overflow) begin
         st_next.flags[fsic_pkg::FL_TMR0] = 1'b1;
      end
      if (src_in.tmr1_overflow) begin
         st_next.flags[fsic_pkg::FL_TMR1] = 1'b1;
      end
      if (src_in.serial_event) begin
         st_next.flags[fsic_pkg::FL_SERIAL] = 1'b1;
      end
      if (src_in.display_event) begin
         st_next.flags[fsic_pkg::FL_DISPLAY] = 1'b1;
      end
      if (src_in.host_switch) begin
         st_next.flags[fsic_pkg::FL_HOSTSW] = 1'b1;
      end

      // Sample every cycle; a blocked poll is simply dropped
      st_next.sample = raw_req;

      // Return ends the innermost level only
      if (return_from_interrupt) begin
         if (st_reg.in_prog_hi) begin
            st_next.in_prog_hi = 1'b0;
         end else begin
            st_next.in_prog_lo = 1'b0;
         end
      end

      // Vectoring handshake
      case (st_reg.state)
         fsic_pkg::FSIC_IDLE: begin
            st_next.vec.valid = 1'b0;
            if (arb_found && core_poll_ok && !return_from_interrupt) begin
               st_next.vec.valid      = 1'b1;
               st_next.vec.source     = arb_winner;
               st_next.vec.vector     = vec_of(arb_winner);
               st_next.vec.high_level = arb_high;
               st_next.state          = fsic_pkg::FSIC_OFFER;
            end
         end
         fsic_pkg::FSIC_OFFER: begin
            if (vector_taken) begin
               st_next.vec.valid = 1'b0;
               if (st_reg.vec.high_level) begin
                  st_next.in_prog_hi = 1'b1;
               end else begin
                  st_next.in_prog_lo = 1'b1;
               end
               st_next.state = fsic_pkg::FSIC_WAIT;
            end
         end
         default: begin
            // One cycle for flags to settle before the next poll
            st_next.state = fsic_pkg::FSIC_IDLE;
         end
      endcase

      // Register reads
      if (avs_read && !st_reg.rd_ack) begin
         st_next.rd_ack = 1'b1;
         if (avs_address == fsic_pkg::ADDR_ENABLE) begin
            st_next.rdata = {24'h0, st_reg.enable};
         end else if (avs_address == fsic_pkg::ADDR_PRIORITY) begin
            st_next.rdata = {24'h0, st_reg.priority_};
         end else if (avs_address == fsic_pkg::ADDR_TCTRL) begin
            st_next.rdata = {24'h0, st_reg.tctrl};
         end else if (avs_address == fsic_pkg::ADDR_FLAGS) begin
            st_next.rdata = {22'h0, st_reg.in_prog_hi, st_reg.in_prog_lo,
                             1'b0, st_reg.flags};
         end else begin
            st_next.rdata = fsic_pkg::UNMAPPED_DATA;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg           <= '0;
         st_reg.enable    <= fsic_pkg::ENABLE_RST;
         st_reg.priority_ <= fsic_pkg::PRIORITY_RST;
         st_reg.tctrl     <= fsic_pkg::TCTRL_RST;
         st_reg.flags     <= fsic_pkg::FLAGS_RST;
         st_reg.state     <= fsic_pkg::FSIC_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs; wait one cycle on every access
   assign avs_waitrequest = (avs_read && !st_reg.rd_ack) || (avs_write && !st_reg.wr_ack);
   assign avs_readdata    = st_reg.rdata;
   assign vec_out         = st_reg.vec;
   assign level_busy      = {st_reg.in_prog_hi, st_reg.in_prog_lo};

endmodule

`default_nettype wire

// ==== src/fsic_pkg.sv ====
package fsic_pkg;

   // ==========================================================
   // Source indices, in polling order (0 polls first)
   localparam int unsigned NUM_SRC     = 5;
   localparam logic [2:0]  SRC_MODE    = 3'h0;
   localparam logic [2:0]  SRC_DDC     = 3'h1;
   localparam logic [2:0]  SRC_TMR0    = 3'h2;
   localparam logic [2:0]  SRC_EXT1    = 3'h3;
   localparam logic [2:0]  SRC_TMR1    = 3'h4;

   // ==========================================================
   // Register byte addresses (word aligned)
   localparam logic [3:0]  ADDR_ENABLE   = 4'h0;
   localparam logic [3:0]  ADDR_PRIORITY = 4'h4;
   localparam logic [3:0]  ADDR_TCTRL    = 4'h8;
   localparam logic [3:0]  ADDR_FLAGS    = 4'hc;

   // ==========================================================
   // Field positions
   // Enable register: bit 7 global, bits 5,3,2,1,0 sources
   localparam int unsigned EN_GLOBAL_BIT  = 7;
   localparam int unsigned EN_DDC_BIT     = 5;
   localparam int unsigned EN_TMR1_BIT    = 3;
   localparam int unsigned EN_EXT1_BIT    = 2;
   localparam int unsigned EN_TMR0_BIT    = 1;
   localparam int unsigned EN_MODE_BIT    = 0;
   // Timer control: trigger selects
   localparam int unsigned TC_MODE_TRIG   = 0;
   localparam int unsigned TC_EXT1_TRIG   = 2;
   // Flags register bit positions
   localparam int unsigned FL_MODE        = 0;
   localparam int unsigned FL_EXT1        = 1;
   localparam int unsigned FL_TMR0        = 2;
   localparam int unsigned FL_TMR1        = 3;
   localparam int unsigned FL_SERIAL      = 4;
   localparam int unsigned FL_DISPLAY     = 5;
   localparam int unsigned FL_HOSTSW      = 6;
   // Bus answer on unmapped reads
   localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  ENABLE_RST    = 8'h00;
   localparam logic [7:0]  PRIORITY_RST  = 8'h00;
   localparam logic [7:0]  TCTRL_RST     = 8'h00;
   localparam logic [6:0]  FLAGS_RST     = 7'h00;

   // ==========================================================
   // Vector addresses, indexed by source
   localparam logic [15:0] VEC_MODE      = 16'h0003;
   localparam logic [15:0] VEC_DDC       = 16'h002b;
   localparam logic [15:0] VEC_TMR0      = 16'h000b;
   localparam logic [15:0] VEC_EXT1      = 16'h0013;
   localparam logic [15:0] VEC_TMR1      = 16'h001b;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } fsic_bus_req_t;

   typedef struct packed {
      logic        mode_change;     // Mode detector change level
      logic        ext1_pin;        // External input one (async pin)
      logic        tmr0_overflow;   // One-cycle pulses from timers
      logic        tmr1_overflow;
      logic        serial_event;    // Serial interface event pulse
      logic        display_event;   // Display channel event pulse
      logic        host_switch;     // Host switch event pulse
   } fsic_src_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  source;
      logic [15:0] vector;
      logic        high_level;
   } fsic_vec_t;

   typedef enum logic [1:0] {
      FSIC_IDLE,
      FSIC_OFFER,
      FSIC_WAIT
   } fsic_state_t;

endpackage

// ==== src/fsic_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for asynchronous level inputs
module fsic_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ==========================================================
   // Stage registers
   logic [WIDTH-1:0] meta_reg;   // First stage, read only by second
   logic [WIDTH-1:0] sync_reg;   // Second stage, safe to use

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule

`default_nettype wire

// ==== src/fsic_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none

// Combinational winner pick: high level first, then polling order
module fsic_arbiter (
   input  wire logic [4:0] request,
   input  wire logic [4:0] high_sel,
   input  wire logic       allow_low,
   input  wire logic       allow_high,
   output logic            found,
   output logic [2:0]      winner,
   output logic            winner_high
);

   // ==========================================================
   // Lowest set index wins (index 0 polls first)
   function automatic logic [2:0] first_set(input logic [4:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 4; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   logic [4:0] hi_req;   // Requests at high level
   logic [4:0] lo_req;   // Requests at low level

   // High level beats low in the same cycle
   always_comb begin
      hi_req      = allow_high ? (request & high_sel) : 5'h00;
      lo_req      = allow_low ? (request & ~high_sel) : 5'h00;
      found       = 1'b0;
      winner      = 3'h0;
      winner_high = 1'b0;
      if (|hi_req) begin
         found       = 1'b1;
         winner      = first_set(hi_req);
         winner_high = 1'b1;
      end else if (|lo_req) begin
         found       = 1'b1;
         winner      = first_set(lo_req);
      end
   end

endmodule

`default_nettype wire

// ==== verif/fsic_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Checker on the top-level ports
module fsic_monitor (
   input wire logic                ref_clk,
   input wire logic                rst_b,
   input wire logic [3:0]          avs_address,
   input wire logic                avs_write,
   input wire logic [31:0]         avs_writedata,
   input wire logic                avs_waitrequest,
   input wire logic                vector_taken,
   input wire logic                return_from_interrupt,
   input wire fsic_pkg::fsic_vec_t vec_out,
   input wire logic [1:0]          level_busy
);
   logic [7:0] en_reg;  // Shadow of the enable register
   logic [7:0] en_next;
   logic [7:0] old_reg; // Shadow one cycle late, as the poll saw it
   logic       src_en;  // Enable bit of the offered source
   // Shadow moves only on a completed write
   always_comb begin
      en_next = en_reg;
      if (avs_write && !avs_waitrequest && avs_address == fsic_pkg::ADDR_ENABLE) begin
         en_next = avs_writedata[7:0];
      end
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         en_reg  <= fsic_pkg::ENABLE_RST;
         old_reg <= fsic_pkg::ENABLE_RST;
      end else begin
         en_reg  <= en_next;
         old_reg <= en_reg;
      end
   end
   // Enable bits sit apart from the source order
   always_comb begin
      case (vec_out.source)
         3'h0: src_en = old_reg[0];
         3'h1: src_en = old_reg[5];
         3'h2: src_en = old_reg[1];
         3'h3: src_en = old_reg[2];
         default: src_en = old_reg[3];
      endcase
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_global_gate: assert property ($rose(vec_out.valid) |-> old_reg[7])
      else $error("offer while globally disabled");
   a_source_gate: assert property ($rose(vec_out.valid) |-> src_en)
      else $error("offer from a disabled source");
   a_take_busy: assert property (vec_out.valid && vector_taken |=>
      !vec_out.valid && level_busy[$past(vec_out.high_level)])
      else $error("call did not mark its level busy");
   a_high_blocks: assert property ($rose(vec_out.valid) |-> !$past(level_busy[1]))
      else $error("offer during high service");
   a_low_preempt: assert property ($rose(vec_out.valid) && $past(level_busy[0]) |-> vec_out.high_level)
      else $error("low offer during low service");
   a_ret_only: assert property ($fell(level_busy[0]) || $fell(level_busy[1]) |-> $past(return_from_interrupt))
      else $error("busy level ended without return");
   a_ret_ends: assert property (return_from_interrupt && level_busy[1] |=> !level_busy[1])
      else $error("return left high level busy");
   a_busy_cause: assert property ($rose(level_busy[0]) |->
      $past(vector_taken) && $past(vec_out.valid) && !$past(vec_out.high_level))
      else $error("low level busy without a call");
endmodule
`default_nettype wire

// ==== verif/fsic_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Core model: takes offers after a delay, returns on command
module fsic_core_model (
   input  wire logic                ref_clk,
   input  wire logic                rst_b,
   input  wire fsic_pkg::fsic_vec_t vec_out,
   input  wire logic [1:0]          take_delay, // Cycles before the call
   input  wire logic                ret_go,     // Bench asks for a return
   output logic                     core_poll_ok,
   output logic                     vector_taken,
   output logic                     return_from_interrupt
);
   logic [1:0] wait_cnt; // Cycles the offer has stood
   // Odd delay means a slow core that polls on alternate cycles
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         core_poll_ok          <= 1'b0;
         vector_taken          <= 1'b0;
         return_from_interrupt <= 1'b0;
         wait_cnt              <= 2'h0;
      end else begin
         core_poll_ok          <= ~core_poll_ok | ~take_delay[0];
         return_from_interrupt <= ret_go;
         vector_taken          <= 1'b0;
         wait_cnt              <= 2'h0;
         if (vec_out.valid && !vector_taken) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (wait_cnt == take_delay) begin
               vector_taken <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/fsic_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsic_top_tb;
   // =====================================================
   // Signals
   logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   fsic_pkg::fsic_src_t src;
   fsic_pkg::fsic_vec_t vec_out;
   logic core_poll_ok, vector_taken, return_from_interrupt, ret_go;
   logic [1:0] take_delay, level_busy;
   logic [31:0] rq[$]; // Expected read data
   logic [19:0] vq[$]; // Expected {source, vector, level}
   int failures, check_count, seed;
   localparam logic [15:0] VEC_TAB [0:4] = '{fsic_pkg::VEC_MODE, fsic_pkg::VEC_DDC,
      fsic_pkg::VEC_TMR0, fsic_pkg::VEC_EXT1, fsic_pkg::VEC_TMR1};
   fsic_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .src_in(src), .core_poll_ok(core_poll_ok),
      .vector_taken(vector_taken), .return_from_interrupt(return_from_interrupt),
      .vec_out(vec_out), .level_busy(level_busy));
   fsic_core_model core_u (.ref_clk(ref_clk), .rst_b(rst_b), .vec_out(vec_out), .take_delay(take_delay),
      .ret_go(ret_go), .core_poll_ok(core_poll_ok), .vector_taken(vector_taken),
      .return_from_interrupt(return_from_interrupt));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // =====================================================
   // Tasks
   task cmp_reg(input logic [31:0] e, input logic [31:0] a);
      check_count++;
      if (a !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask
   task cmp_vec(input logic [19:0] e, input logic [19:0] a);
      cmp_reg({12'h0, e}, {12'h0, a});
   endtask
   task give_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Bus access; a read notes its expected data
   task acc(input logic rd, input logic [3:0] a, input logic [31:0] d);
      if (rd) rq.push_back(d);
      @(posedge ref_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= rd;
      avs_write     <= !rd;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Mask bit per source; pins are active low
   task fire(input logic [4:0] m);
      @(posedge ref_clk);
      src <= '{mode_change: !m[0], ext1_pin: !m[3], tmr0_overflow: m[2], tmr1_overflow: m[4],
               serial_event: m[1], display_event: m[1], host_switch: m[1]};
      @(posedge ref_clk);
      src <= '{mode_change: !m[0], ext1_pin: !m[3], default: 1'b0};
      @(posedge ref_clk);
      src <= '{mode_change: 1'b1, ext1_pin: 1'b1, default: 1'b0};
   endtask
   // Note the expected call, then wait for it
   task serve(input logic [2:0] s, input logic hi);
      vq.push_back({s, VEC_TAB[s], hi});
      repeat (200) begin
         @(posedge ref_clk);
         if (vec_out.valid === 1'b1 && vector_taken === 1'b1) break;
      end
   endtask
   task ret();
      @(posedge ref_clk);
      ret_go     <= 1'b1;
      take_delay <= 2'($random(seed));
      @(posedge ref_clk);
      ret_go <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   // =====================================================
   // Scoreboard: oldest note against each result
   always @(posedge ref_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
         cmp_reg(rq.size() > 0 ? rq.pop_front() : 'x, avs_readdata);
      if (vec_out.valid === 1'b1 && vector_taken === 1'b1)
         cmp_vec(vq.size() > 0 ? vq.pop_front() : 'x, {vec_out.source, vec_out.vector, vec_out.high_level});
   end
   // Hang guard, far beyond the expected run
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      give_verdict();
   end
   // =====================================================
   // Main sequence; offsets 0 enable, 4 priority, 8 trigger, c flags
   initial begin
      seed = 32'h8c7a;
      failures = 0;
      check_count = 0;
      {rst_b, avs_read, avs_write, ret_go, avs_address, avs_writedata, take_delay} = '0;
      src = '{mode_change: 1'b1, ext1_pin: 1'b1, default: 1'b0};
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      acc(1'b0, 4'hc, 32'h0);
      for (int i = 0; i < 4; i++) acc(1'b1, 4'(4 * i), 32'h0);
      acc(1'b0, 4'h2, 32'hff);
      acc(1'b1, 4'h2, 32'h0);
      acc(1'b0, 4'h8, 32'h05);
      acc(1'b0, 4'h0, 32'haf);
      for (int s = 0; s < 5; s++) begin
         fire(5'(1 << s));
         serve(3'(s), 1'b0);
         acc(1'b1, 4'hc, s == 1 ? 32'h170 : 32'h100);
         if (s == 1) acc(1'b0, 4'hc, 32'h0);
         ret();
      end
      acc(1'b0, 4'h0, 32'h2f);
      fire(5'h1f);
      repeat (8) @(posedge ref_clk);
      acc(1'b1, 4'hc, 32'h7f);
      acc(1'b0, 4'h0, 32'haf);
      for (int s = 0; s < 5; s++) begin
         serve(3'(s), 1'b0);
         if (s == 1) acc(1'b0, 4'hc, 32'h0e);
         ret();
      end
      acc(1'b0, 4'h4, 32'h08);
      acc(1'b0, 4'h0, 32'h2f);
      fire(5'h14);
      acc(1'b0, 4'h0, 32'haf);
      serve(3'h4, 1'b1);
      repeat (8) @(posedge ref_clk);
      ret();
      serve(3'h2, 1'b0);
      fire(5'h11);
      serve(3'h4, 1'b1);
      ret();
      repeat (8) @(posedge ref_clk);
      ret();
      serve(3'h0, 1'b0);
      ret();
      acc(1'b0, 4'h4, 32'h0);
      acc(1'b0, 4'h8, 32'h01);
      @(posedge ref_clk);
      src.ext1_pin <= 1'b0;
      serve(3'h3, 1'b0);
      ret();
      serve(3'h3, 1'b0);
      @(posedge ref_clk);
      src.ext1_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ret();
      acc(1'b0, 4'h0, 32'h2f);
      @(posedge ref_clk);
      src.ext1_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      src.ext1_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      acc(1'b0, 4'h0, 32'haf);
      repeat (10) @(posedge ref_clk);
      acc(1'b1, 4'hc, 32'h0);
      @(posedge ref_clk);
      cmp_reg(32'h0, 32'(vq.size() + rq.size()));
      give_verdict();
   end
endmodule
bind fsic_top fsic_monitor mon_u (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .vector_taken(vector_taken), .return_from_interrupt(return_from_interrupt),
   .vec_out(vec_out), .level_busy(level_busy));
`default_nettype wire
